// ==== verilog/mode_sequencer_listen_ctrl.v ====
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "mode_seq_defines.vh"
module mode_sequencer_listen_ctrl #(
  parameter OSC_WAKE_US = 500,
  parameter SYNTH_WAKE_US = 60,
  parameter OSC_WAKE_CYC = OSC_WAKE_US * `CLK_MHZ,
  parameter RC_CAL_TICKS = 16
) (
  input wire core_clk_in,
  input wire rst_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire pll_locked_in,
  input wire rc_tick_in,
  input wire rssi_above_in,
  input wire sync_word_match_in,
  input wire payload_ready_in,
  input wire rx_timeout_in,
  input wire tx_launch_condition_in,
  input wire demod_data_in,
  input wire serial_data_pin_in,
  output reg serial_data_pin_out,
  output wire serial_data_pin_oe_out,
  output reg modulator_data_out,
  output wire osc_on_out,
  output wire synth_on_out,
  output wire amp_reg_on_out,
  output wire amp_ramp_on_out,
  output wire rx_on_out,
  output wire rc_on_out,
  output wire synth_lock_out,
  output wire recovered_bit_clock_out,
  output wire tx_preamble_out,
  output reg tx_packet_start_out,
  output wire bitsync_locked_out,
  output reg target_mode_reached_out,
  output reg transmit_prepared_out,
  output reg receive_prepared_out
);
  localparam S_SLEEP = 3'h0;
  localparam S_STBY = 3'h1;
  localparam S_SYNTH = 3'h2;
  localparam S_TX = 3'h3;
  localparam S_RX = 3'h4;
  localparam S_LIDLE = 3'h5;
  localparam S_LRX = 3'h6;
  localparam S_LHOLD = 3'h7;
  localparam [19:0] SYNTH_CYC = SYNTH_WAKE_US * `CLK_MHZ;
  localparam [19:0] OSC_CYC = OSC_WAKE_CYC;
  localparam [19:0] SETTLE_CYC = `TX_SETTLE_US * `CLK_MHZ;
  localparam [19:0] ANA_CYC = `ANA_US * `CLK_MHZ;
  localparam [19:0] PLLAFC_CYC =
    (`PLLAFC_NUM * `CLK_MHZ * 1000 + `PLL_BW_KHZ - 1) / `PLL_BW_KHZ;
  localparam [15:0] CAL_TICKS = RC_CAL_TICKS;
  localparam [3:0] SYNC_N = `SYNC_BITS;

  // Resolution code to RC ticks per step; 00 is treated as 01
  function [11:0] step_ticks;
    input [1:0] code;
    begin
      case (code)
        2'h2: step_ticks = `STEP_4MS;
        2'h3: step_ticks = `STEP_262MS;
        default: step_ticks = `STEP_64US;
      endcase
    end
  endfunction

  // Channel filter settle, rounded up to whole cycles
  function [19:0] filter_cyc;
    input [7:0] bw_khz;
    input ook;
    reg [31:0] num;
    reg [31:0] den;
    reg [31:0] quo;
    begin
      num = (ook ? `CF_OOK_NUM : `CF_FSK_NUM) * `CLK_MHZ * 1000;
      den = 4 * {24'h000000, (bw_khz == 8'h00 ? 8'h01 : bw_khz)};
      quo = (num + den - 32'h1) / den;
      filter_cyc = quo[19:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] op_mode;
  reg [7:0] data_cfg;
  reg [7:0] amp_ramp_time;
  reg [7:0] bit_period;
  reg [7:0] channel_bandwidth;
  reg [7:0] idle_mult;
  reg [7:0] rx_mult;
  reg [7:0] resol;
  reg [2:0] state;
  reg [19:0] elapsed;
  reg [19:0] limit;
  reg [11:0] step_cnt;
  reg [7:0] mult_cnt;
  reg [15:0] cal_cnt;
  reg rc_cal_done;
  reg stopped;
  reg settled_q;
  reg tx_ready_q;
  reg rx_ready_q;
  reg launched;
  reg [12:0] half_cnt;
  reg bit_clk;
  reg [3:0] sync_cnt;
  reg [2:0] next_state;
  reg [19:0] next_limit;
  reg next_stopped;

  wire [2:0] mode = op_mode[`F_MODE_LO +: 3];
  wire cancel = op_mode[`F_CANCEL];
  wire enable = op_mode[`F_ENABLE];
  wire bypass = op_mode[`F_BYPASS];
  wire ook = data_cfg[`F_OOK];
  wire packet_mode = data_cfg[`F_PACKET];
  wire bitsync_on = data_cfg[`F_BITSYNC] | packet_mode;
  wire afc_on = data_cfg[`F_AFC];
  wire wake_accept_rule = data_cfg[`F_ACCEPT];
  wire [1:0] cycle_end_action = data_cfg[`F_END_LO +: 2];
  // Full-width products, then cut to the counter widths on purpose
  wire [31:0] tbit_full = bit_period * `CLK_MHZ;
  wire [31:0] ramp_full =
    (amp_ramp_time * `CLK_MHZ * `RAMP_NUM + `RAMP_DEN - 1) / `RAMP_DEN;
  wire [12:0] tbit_cyc = tbit_full[12:0];
  wire [12:0] half_bit = {1'b0, tbit_cyc[12:1]};
  wire [19:0] ramp_cyc = ramp_full[19:0];
  wire [19:0] tx_cyc = SETTLE_CYC + (ook ? 20'h00000 : ramp_cyc) +
    {7'h00, half_bit};
  wire [19:0] afc_cyc = PLLAFC_CYC + {5'h00, tbit_cyc, 2'h0};
  wire [19:0] rx_cyc = ANA_CYC + filter_cyc(channel_bandwidth, ook) +
    (afc_on ? afc_cyc : 20'h00000);
  wire done = elapsed >= limit;
  // Codes above receive have no meaning and park the device in standby
  wire [2:0] mode_map = (mode > `MODE_RX) ? `MODE_STBY : mode;
  wire listen_on = enable & ~stopped;
  wire [2:0] tgt = listen_on ? S_STBY : mode_map;
  wire in_listen = (state == S_LIDLE) | (state == S_LRX) |
    (state == S_LHOLD);
  wire rf_on = (state == S_SYNTH) | (state == S_TX) | (state == S_RX) |
    (state == S_LRX) | (state == S_LHOLD);
  wire settled = done & (~rf_on | pll_locked_in) &
    (in_listen | (state == tgt));
  wire tx_ready = settled & (state == S_TX);
  wire rx_ready = settled &
    ((state == S_RX) | (state == S_LRX) | (state == S_LHOLD));
  wire [11:0] step = step_ticks((state == S_LRX) ?
    resol[`F_RES_RX_LO +: 2] : resol[`F_RES_IDLE_LO +: 2]);
  wire [7:0] win_mult = (state == S_LRX) ? rx_mult : idle_mult;
  wire win_done = (mult_cnt >= win_mult);
  wire accept = rssi_above_in &
    (~wake_accept_rule | sync_word_match_in);
  wire packet_end = payload_ready_in | rx_timeout_in;
  wire state_chg = (next_state != state);

  ////////////////////////////////////////////////////////////////////////
  // Mode sequencer; each move except bypass from sleep to standby or synth (which loads 0) loads the wake count of the block it enables
  always @* begin
    next_state = state;
    next_limit = limit;
    next_stopped = stopped & enable;
    case (state)
      S_SLEEP: begin
        if (tgt != S_SLEEP) begin
          if (bypass) begin
            next_state = tgt;
            next_limit = (tgt == S_TX) ? tx_cyc :
              (tgt == S_RX) ? rx_cyc : 20'h00000;
          end else begin
            next_state = S_STBY;
            next_limit = OSC_CYC;
          end
        end
      end
      S_STBY: begin
        if (done) begin
          if (listen_on & rc_cal_done) begin
            next_state = S_LIDLE;
            next_limit = 20'h00000;
          end else if (tgt == S_SLEEP) begin
            next_state = S_SLEEP;
          end else if (tgt != S_STBY) begin
            next_state = bypass ? tgt : S_SYNTH;
            next_limit = !bypass ? SYNTH_CYC : (tgt == S_TX) ? tx_cyc :
              (tgt == S_RX) ? rx_cyc : SYNTH_CYC;
          end
        end
      end
      S_SYNTH: begin
        // Transmit and receive wait for lock so no splatter leaves
        if (tgt == S_SLEEP || tgt == S_STBY) begin
          next_state = tgt;
          next_limit = 20'h00000;
        end else if (done & pll_locked_in) begin
          if (tgt == S_TX) begin
            next_state = S_TX;
            next_limit = tx_cyc;
          end else if (tgt == S_RX) begin
            next_state = S_RX;
            next_limit = rx_cyc;
          end
        end
      end
      S_TX, S_RX: begin
        // Synthesizer stays up, so other modes are entered directly
        if (tgt != state) begin
          next_state = tgt;
          next_limit = (tgt == S_TX) ? tx_cyc :
            (tgt == S_RX) ? rx_cyc : 20'h00000;
        end
      end
      S_LIDLE: begin
        if (win_done) begin
          next_state = S_LRX;
          next_limit = rx_cyc;
        end
      end
      S_LRX: begin
        if (settled & accept) begin
          next_state = S_LHOLD;
          next_limit = 20'h00000;
        end else if (win_done) begin
          next_state = S_LIDLE;
        end
      end
      default: begin
        if (packet_end && cycle_end_action == 2'h1) begin
          next_state = S_SYNTH;
          next_limit = 20'h00000;
          next_stopped = 1'b1;
        end else if (packet_end && cycle_end_action == 2'h2) begin
          next_state = S_LIDLE;
        end
      end
    endcase
    // Cancel with enable cleared overrides any listen phase and returns to normal sequencing
    if (in_listen & cancel & ~enable) begin
      next_state = S_STBY;
      next_limit = OSC_CYC;
    end
  end

  // State, wake counter and listen window counters
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= S_SLEEP;
      limit <= 20'h00000;
      elapsed <= 20'h00000;
      step_cnt <= 12'h000;
      mult_cnt <= 8'h00;
      stopped <= 1'b0;
    end else begin
      state <= next_state;
      limit <= next_limit;
      stopped <= next_stopped;
      if (state_chg) begin
        elapsed <= 20'h00000;
      end else if (!done) begin
        elapsed <= elapsed + 20'h00001;
      end
      // Windows start at entry, so receive wake eats into the window
      if (state_chg) begin
        step_cnt <= 12'h000;
        mult_cnt <= 8'h00;
      end else if (rc_tick_in && !win_done) begin
        if (step_cnt + 12'h001 >= step) begin
          step_cnt <= 12'h000;
          mult_cnt <= mult_cnt + 8'h01;
        end else begin
          step_cnt <= step_cnt + 12'h001;
        end
      end
    end
  end

  // RC calibration runs once after reset; listen waits for it
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cal_cnt <= 16'h0000;
      rc_cal_done <= 1'b0;
    end else if (rc_tick_in && !rc_cal_done) begin
      cal_cnt <= cal_cnt + 16'h0001;
      rc_cal_done <= (cal_cnt + 16'h0001 >= CAL_TICKS);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Block enables
  assign rc_on_out = 1'b1;
  assign osc_on_out = (state != S_SLEEP) & (state != S_LIDLE);
  assign synth_on_out = rf_on;
  assign synth_lock_out = rf_on & pll_locked_in;
  assign amp_reg_on_out = (state == S_TX);
  assign amp_ramp_on_out = (state == S_TX) & (elapsed >= SETTLE_CYC);
  assign rx_on_out = (state == S_RX) | (state == S_LRX) | (state == S_LHOLD);
  assign tx_preamble_out = tx_ready & packet_mode;
  assign bitsync_locked_out = rx_ready & bitsync_on &
    (sync_cnt >= SYNC_N);
  // Bit clock runs once transmit is usable, after ramp-up, or once receive is usable outside packet mode
  assign recovered_bit_clock_out = bit_clk & (tx_ready | (rx_ready &
    ~packet_mode));
  assign serial_data_pin_oe_out = rx_ready & ~packet_mode;

  // Recovered bit clock and synchronizer preamble count
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      half_cnt <= 13'h0000;
      bit_clk <= 1'b0;
      sync_cnt <= 4'h0;
    end else begin
      if (!(tx_ready | rx_ready)) begin
        half_cnt <= 13'h0000;
        bit_clk <= 1'b0;
      end else if (half_cnt + 13'h0001 >= half_bit) begin
        half_cnt <= 13'h0000;
        bit_clk <= ~bit_clk;
      end else begin
        half_cnt <= half_cnt + 13'h0001;
      end
      if (!rx_ready) begin
        sync_cnt <= 4'h0;
      end else if (half_cnt + 13'h0001 >= half_bit && !bit_clk &&
          sync_cnt < SYNC_N) begin
        sync_cnt <= sync_cnt + 4'h1;
      end
    end
  end

  // Data paths and one-cycle readiness events
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      serial_data_pin_out <= 1'b0;
      modulator_data_out <= 1'b0;
      settled_q <= 1'b0;
      tx_ready_q <= 1'b0;
      rx_ready_q <= 1'b0;
      launched <= 1'b0;
      tx_packet_start_out <= 1'b0;
      target_mode_reached_out <= 1'b0;
      transmit_prepared_out <= 1'b0;
      receive_prepared_out <= 1'b0;
    end else begin
      // Synchronizer holds data back until preamble lock
      serial_data_pin_out <= (bitsync_on & ~bitsync_locked_out) ? 1'b0 :
        demod_data_in;
      modulator_data_out <= tx_ready & ~packet_mode & serial_data_pin_in;
      settled_q <= settled & ~in_listen;
      tx_ready_q <= tx_ready;
      rx_ready_q <= rx_ready;
      target_mode_reached_out <= settled & ~in_listen & ~settled_q;
      transmit_prepared_out <= tx_ready & ~tx_ready_q;
      receive_prepared_out <= rx_ready & ~rx_ready_q;
      launched <= tx_ready & packet_mode &
        (launched | tx_launch_condition_in);
      tx_packet_start_out <= tx_ready & packet_mode & ~launched &
        tx_launch_condition_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      op_mode <= `RST_OP_MODE;
      data_cfg <= `RST_CONFIG;
      amp_ramp_time <= `RST_RAMP;
      bit_period <= `RST_BIT_PERIOD;
      channel_bandwidth <= `RST_BANDWIDTH;
      idle_mult <= `RST_MULT;
      rx_mult <= `RST_MULT;
      resol <= `RST_RESOL;
    end else if (wr_in) begin
      case (addr_in)
        `OFS_OP_MODE: op_mode <= wdata_in;
        `OFS_CONFIG: data_cfg <= wdata_in;
        `OFS_RAMP: amp_ramp_time <= wdata_in;
        `OFS_BIT_PERIOD: bit_period <= wdata_in;
        `OFS_BANDWIDTH: channel_bandwidth <= wdata_in;
        `OFS_IDLE_MULT: idle_mult <= wdata_in;
        `OFS_RX_MULT: rx_mult <= wdata_in;
        `OFS_RESOL: resol <= {4'h0, wdata_in[3:0]};
        default: ;
      endcase
    end
  end

  // Register reads, data in the cycle after the strobe; unmapped reads 0
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `OFS_OP_MODE: rdata_out <= op_mode;
        `OFS_CONFIG: rdata_out <= data_cfg;
        `OFS_RAMP: rdata_out <= amp_ramp_time;
        `OFS_BIT_PERIOD: rdata_out <= bit_period;
        `OFS_BANDWIDTH: rdata_out <= channel_bandwidth;
        `OFS_IDLE_MULT: rdata_out <= idle_mult;
        `OFS_RX_MULT: rdata_out <= rx_mult;
        `OFS_RESOL: rdata_out <= resol;
        `OFS_STATUS: rdata_out <= {rc_cal_done, synth_lock_out, rx_ready,
          tx_ready, settled, state};
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end
endmodule // mode_sequencer_listen_ctrl

// ==== include/mode_seq_defines.vh ====
`ifndef MODE_SEQ_DEFINES_VH
`define MODE_SEQ_DEFINES_VH
// Register offsets
`define OFS_OP_MODE 4'h0
`define OFS_CONFIG 4'h1
`define OFS_RAMP 4'h2
`define OFS_BIT_PERIOD 4'h3
`define OFS_BANDWIDTH 4'h4
`define OFS_IDLE_MULT 4'h5
`define OFS_RX_MULT 4'h6
`define OFS_RESOL 4'h7
`define OFS_STATUS 4'h8
// Field positions, op_mode
`define F_MODE_LO 0
`define F_CANCEL 5
`define F_ENABLE 6
`define F_BYPASS 7
// Field positions, config
`define F_OOK 0
`define F_PACKET 1
`define F_BITSYNC 2
`define F_AFC 3
`define F_ACCEPT 4
`define F_END_LO 5
// Field positions, resolutions
`define F_RES_IDLE_LO 0
`define F_RES_RX_LO 2
// Reset values
`define RST_OP_MODE 8'h01
`define RST_CONFIG 8'h06
`define RST_RAMP 8'h28
`define RST_BIT_PERIOD 8'h0a
`define RST_BANDWIDTH 8'h0a
`define RST_MULT 8'h01
`define RST_RESOL 8'h05
// Mode codes
`define MODE_SLEEP 3'h0
`define MODE_STBY 3'h1
`define MODE_SYNTH 3'h2
`define MODE_TX 3'h3
`define MODE_RX 3'h4
// Timing figures
`define CLK_MHZ 25
`define TX_SETTLE_US 5
`define RAMP_NUM 5
`define RAMP_DEN 4
`define ANA_US 20
`define CF_FSK_NUM 21
`define CF_OOK_NUM 34
`define PLLAFC_NUM 5
`define PLL_BW_KHZ 300
`define AFC_BITS 4
`define SYNC_BITS 12
// Window steps in RC ticks (one tick is 64 us)
`define STEP_64US 12'h001
`define STEP_4MS 12'h040
`define STEP_262MS 12'hfff
`endif

// ==== verif/mode_seq_sva.sv ====
`timescale 1ns/1ps
`include "mode_seq_defines.vh"
module mode_seq_sva (
  input wire core_clk_in,
  input wire rst_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire pll_locked_in,
  input wire demod_data_in,
  input wire tx_launch_condition_in,
  input wire serial_data_pin_out,
  input wire serial_data_pin_oe_out,
  input wire osc_on_out,
  input wire synth_on_out,
  input wire amp_reg_on_out,
  input wire amp_ramp_on_out,
  input wire rx_on_out,
  input wire synth_lock_out,
  input wire recovered_bit_clock_out,
  input wire tx_preamble_out,
  input wire tx_packet_start_out,
  input wire target_mode_reached_out,
  input wire transmit_prepared_out,
  input wire receive_prepared_out
);
  reg byp;
  reg [7:0] cfg;
  wire raw;
  // Shadow of bypass and data mode; bypass may skip the lock wait
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      byp <= 1'b0;
      cfg <= `RST_CONFIG;
    end else if (wr_in && addr_in == `OFS_OP_MODE) begin
      byp <= wdata_in[`F_BYPASS];
    end else if (wr_in && addr_in == `OFS_CONFIG) begin
      cfg <= wdata_in;
    end
  end
  assign raw = !cfg[`F_PACKET] && !cfg[`F_BITSYNC];
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_rx_pulse;
    rx_on_out ##1 !receive_prepared_out;
  endsequence
  sequence s_one_launch;
    tx_preamble_out && $past(tx_launch_condition_in) ##1 !tx_packet_start_out;
  endsequence
  a_lock_pin: assert property (
    synth_lock_out == (synth_on_out && pll_locked_in))
    else $error("lock pin wrong");
  a_tx_after_lock: assert property (
    $rose(amp_reg_on_out) && !byp |-> $past(synth_lock_out))
    else $error("transmit entered before lock");
  a_tx_keeps_synth: assert property (
    amp_reg_on_out |-> synth_on_out && osc_on_out)
    else $error("transmit without synthesizer");
  a_ramp_after_reg: assert property (
    $rose(amp_ramp_on_out) |-> $past(amp_reg_on_out, 8))
    else $error("ramp before regulator");
  a_clock_after_ramp: assert property (
    $rose(recovered_bit_clock_out) && amp_reg_on_out |-> amp_ramp_on_out)
    else $error("bit clock before ramp");
  a_tx_event_pair: assert property (
    transmit_prepared_out |-> target_mode_reached_out && amp_ramp_on_out)
    else $error("transmit events not paired");
  a_rx_event_once: assert property (
    receive_prepared_out |-> s_rx_pulse)
    else $error("receive event wrong");
  a_packet_launch: assert property (
    tx_packet_start_out |-> s_one_launch)
    else $error("packet start without launch");
  a_raw_data_pass: assert property (
    raw && serial_data_pin_oe_out && $past(serial_data_pin_oe_out)
      |-> serial_data_pin_out == $past(demod_data_in))
    else $error("raw data not passed");
endmodule // mode_seq_sva
bind mode_sequencer_listen_ctrl mode_seq_sva u_sva (.*);

// ==== verif/mode_seq_far_model.sv ====
`timescale 1ns/1ps
module mode_seq_far_model (
  input wire core_clk_in,
  input wire rst_in,
  input wire synth_on_in,
  input wire slow_in,
  input wire bit_clock_in,
  input wire dev_oe_in,
  input wire dev_data_in,
  output reg pll_lock_out,
  output reg rc_tick_out,
  output reg demod_out,
  output wire pin_out
);
  reg [7:0] lk;
  reg [5:0] rc;
  reg host_bit;
  reg bclk_d;
  // PLL locks a few or many cycles after the synthesizer starts
  always @(posedge core_clk_in) begin
    if (rst_in || !synth_on_in) begin
      lk <= 8'h00;
      pll_lock_out <= 1'b0;
    end else if (lk < (slow_in ? 8'hc8 : 8'h05)) begin
      lk <= lk + 8'h01;
    end else begin
      pll_lock_out <= 1'b1;
    end
  end
  // RC ticks sped up to one per 64 cycles to keep the run short
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      rc <= 6'h00;
      rc_tick_out <= 1'b0;
      host_bit <= 1'b0;
      bclk_d <= 1'b0;
    end else begin
      rc <= rc + 6'h01;
      rc_tick_out <= (rc == 6'h3f);
      demod_out <= rc[0] ^ rc[3];
      bclk_d <= bit_clock_in;
      if (bit_clock_in && !bclk_d)
        host_bit <= ~host_bit;
    end
  end
  // Host releases the pin while the device drives it
  assign pin_out = dev_oe_in ? dev_data_in : host_bit;
endmodule // mode_seq_far_model

// ==== verif/mode_sequencer_listen_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`include "mode_seq_defines.vh"
module mode_sequencer_listen_ctrl_tb_top;
  localparam int RXF = 500 + (21 * 25000 + 999) / 1000;
  localparam int RXA = RXF + (5 * 25000 + 299) / 300 + 4 * 10 * 25;
  localparam int RXO = 500 + (34 * 25000 + 999) / 1000;
  localparam int TXF = 125 + (41 * 125 + 3) / 4 + 10 * 25 / 2;
  localparam int TXO = 125 + 10 * 25 / 2;
  reg core_clk_in, rst_in, wr_in, rd_in, slow;
  reg rssi_above_in, sync_word_match_in, tx_launch_condition_in;
  reg payload_ready_in, rx_timeout_in;
  reg [3:0] addr_in;
  reg [7:0] wdata_in, v;
  wire [7:0] rdata_out;
  wire pll_locked_in, rc_tick_in, demod_data_in, serial_data_pin_in;
  wire serial_data_pin_out, serial_data_pin_oe_out, modulator_data_out;
  wire osc_on_out, synth_on_out, amp_reg_on_out, amp_ramp_on_out;
  wire rx_on_out, rc_on_out, synth_lock_out, recovered_bit_clock_out;
  wire tx_preamble_out, tx_packet_start_out, bitsync_locked_out;
  wire target_mode_reached_out, transmit_prepared_out, receive_prepared_out;
  int num_errors = 0;
  int tests_run = 0;
  int n, i, e;
  logic [7:0] rst_tab [8] = '{`RST_OP_MODE, `RST_CONFIG, `RST_RAMP,
    `RST_BIT_PERIOD, `RST_BANDWIDTH, `RST_MULT, `RST_MULT, `RST_RESOL};
  logic [7:0] rx_cfg [3] = '{8'h00, 8'h08, 8'h04};
  int rx_exp [3] = '{RXF, RXA, RXF};
  // Listen cases: sync, rssi, rule, idle res, idle multiplier
  logic [12:0] lt [4] = '{13'h0103, 13'h0e01, 13'h1d03, 13'h0903};
  mode_sequencer_listen_ctrl #(.OSC_WAKE_CYC(20), .SYNTH_WAKE_US(1),
    .RC_CAL_TICKS(2)) dut (.*);
  mode_seq_far_model far (.core_clk_in, .rst_in, .synth_on_in(synth_on_out),
    .slow_in(slow), .bit_clock_in(recovered_bit_clock_out),
    .dev_oe_in(serial_data_pin_oe_out), .dev_data_in(serial_data_pin_out),
    .pll_lock_out(pll_locked_in), .rc_tick_out(rc_tick_in),
    .demod_out(demod_data_in), .pin_out(serial_data_pin_in));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  // Run should end near 33k cycles; this only catches a hang
  initial begin
    #4000000;
    num_errors++;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////////////////
  task step;
    @(posedge core_clk_in);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task chkr(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("ERROR %0t count %0d not %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask
  // Cycles from the chain switching on to its readiness pulse
  task evt(input logic tx, input int exp);
    n = 0;
    while ((tx ? amp_reg_on_out : rx_on_out) !== 1'b1 && n < 3000) begin
      step;
      n++;
    end
    n = 0;
    while ((tx ? transmit_prepared_out : receive_prepared_out) !== 1'b1
        && n < 5000) begin
      step;
      n++;
    end
    chkr(n, exp, exp + 2);
  endtask
  task ticks(input logic lvl, input int lim);
    n = 0;
    while (rx_on_out === lvl && n < lim) begin
      step;
      if (rc_tick_in === 1'b1)
        n++;
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_in = 1'b1;
    {wr_in, rd_in, slow, rssi_above_in, sync_word_match_in} = 5'h00;
    {tx_launch_condition_in, payload_ready_in, rx_timeout_in} = 3'h0;
    addr_in = 4'h0;
    wdata_in = 8'h00;
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd(`OFS_STATUS, v);
    chk(v[7], 1'b0);
    for (i = 0; i < 8; i++) begin
      rd(i[3:0], v);
      chk(v, rst_tab[i]);
    end
    wr(4'h9, 8'hff);
    rd(4'h9, v);
    chk(v, 8'h00);
    wr(`OFS_RESOL, 8'hff);
    rd(`OFS_RESOL, v);
    chk(v, 8'h0f);
    $display("test registers done");
    // Sleep, then a code past receive that falls back to standby
    wr(`OFS_OP_MODE, 8'h00);
    repeat (3) step;
    chk(osc_on_out, 1'b0);
    wr(`OFS_OP_MODE, 8'h07);
    repeat (30) step;
    rd(`OFS_STATUS, v);
    chk(v[2:0], `MODE_STBY);
    wr(`OFS_OP_MODE, 8'h00);
    wr(`OFS_RAMP, 8'h29);
    wr(`OFS_BANDWIDTH, 8'hfa);
    slow <= 1'b1;
    wr(`OFS_OP_MODE, 8'h03);
    evt(1'b1, TXF);
    chk(tx_preamble_out, 1'b1);
    chk(tx_packet_start_out, 1'b0);
    @(posedge core_clk_in);
    tx_launch_condition_in <= 1'b1;
    n = 0;
    while (tx_packet_start_out !== 1'b1 && n < 5) begin
      step;
      n++;
    end
    chkr(n, 1, 2);
    rd(`OFS_STATUS, v);
    chk(v[2:0], `MODE_TX);
    tx_launch_condition_in <= 1'b0;
    slow <= 1'b0;
    wr(`OFS_OP_MODE, 8'h02);
    wr(`OFS_CONFIG, 8'h01);
    wr(`OFS_OP_MODE, 8'h03);
    evt(1'b1, TXO);
    step;
    v[0] = serial_data_pin_in;
    step;
    chk(modulator_data_out, v[0]);
    $display("test transmit done");
    // Hop out of transmit through receive, then receive hops via synth
    wr(`OFS_OP_MODE, 8'h04);
    evt(1'b0, RXO);
    chk(serial_data_pin_oe_out, 1'b1);
    step;
    v[0] = demod_data_in;
    step;
    chk(serial_data_pin_out, v[0]);
    for (i = 0; i < 3; i++) begin
      wr(`OFS_OP_MODE, 8'h02);
      wr(`OFS_CONFIG, rx_cfg[i]);
      wr(`OFS_OP_MODE, 8'h04);
      evt(1'b0, rx_exp[i]);
    end
    repeat (2700) step;
    chk(bitsync_locked_out, 1'b0);
    chk(serial_data_pin_out, 1'b0);
    repeat (600) step;
    chk(bitsync_locked_out, 1'b1);
    rd(`OFS_STATUS, v);
    chk(v[2:0], `MODE_RX);
    $display("test receive done");
    wr(`OFS_OP_MODE, 8'h01);
    repeat (30) step;
    wr(`OFS_RX_MULT, 8'h28);
    for (i = 0; i < 4; i++) begin
      wr(`OFS_IDLE_MULT, lt[i][7:0]);
      wr(`OFS_RESOL, {6'h01, lt[i][9:8]});
      wr(`OFS_CONFIG, {3'h0, lt[i][10], 4'h0});
      rssi_above_in <= lt[i][11];
      sync_word_match_in <= lt[i][12];
      wr(`OFS_OP_MODE, 8'h41);
      repeat (3) step;
      chk({osc_on_out, rc_on_out}, 2'b01);
      rd(`OFS_STATUS, v);
      chk({v[7], v[2:0]}, 4'hd);
      e = lt[i][7:0] * (lt[i][9] ? 64 : 1);
      ticks(1'b0, 80);
      chkr(n, e - 1, e + 1);
      e = (lt[i][11] && (!lt[i][10] || lt[i][12])) ? 60 : 40;
      ticks(1'b1, 60);
      chkr(n, e - 1, e + 1);
      wr(`OFS_OP_MODE, 8'h21);
      wr(`OFS_OP_MODE, 8'h01);
      repeat (30) step;
    end
    $display("test listen done");
    // Bypass goes from standby straight to transmit
    wr(`OFS_OP_MODE, 8'h83);
    step;
    chk(amp_reg_on_out, 1'b1);
    evt(1'b1, TXF);
    wr(`OFS_OP_MODE, 8'h01);
    repeat (30) step;
    // End actions 01 and 10 after an accepted signal
    for (i = 1; i < 3; i++) begin
      wr(`OFS_CONFIG, i[7:0] << 5);
      wr(`OFS_OP_MODE, 8'h41);
      ticks(1'b0, 80);
      repeat (1100) step;
      rd(`OFS_STATUS, v);
      chk(v[2:0], 3'h7);
      @(posedge core_clk_in);
      {payload_ready_in, rx_timeout_in} <= i[1:0];
      @(posedge core_clk_in);
      {payload_ready_in, rx_timeout_in} <= 2'h0;
      repeat (40) step;
      rd(`OFS_STATUS, v);
      chk(v[2:0], (i == 1) ? `MODE_STBY : 3'h5);
      wr(`OFS_OP_MODE, 8'h21);
      wr(`OFS_OP_MODE, 8'h01);
      repeat (30) step;
    end
    $display("test end actions done");
    print_verdict;
  end
endmodule // mode_sequencer_listen_ctrl_tb_top
